//--- include/vcra_map.svh
`ifndef VCRA_MAP_SVH
`define VCRA_MAP_SVH

// ***************************************************
// offsets
// ***************************************************
`define VCRA_PORT_CAP1 12'h144
`define VCRA_CH0_CAP 12'h150
`define VCRA_CH0_CTRL 12'h154
`define VCRA_CH0_STAT 12'h158
`define VCRA_CH1_CAP 12'h15C
`define VCRA_CH1_CTRL 12'h160
`define VCRA_CH1_STAT 12'h164
`define VCRA_TABLE_BASE 12'h170
`define VCRA_TABLE_LAST 12'h17C

// ***************************************************
// field positions
// ***************************************************
`define VCRA_LOAD_BIT 16
`define VCRA_SEL_LSB 17
`define VCRA_ID_LSB 24
`define VCRA_EN_BIT 31
`define VCRA_TSTAT_BIT 16
`define VCRA_NEG_BIT 17

// ***************************************************
// values
// ***************************************************
`define VCRA_ARB_CAP 8'h19
`define VCRA_SLOTS_RST 7'h7F
`define VCRA_TBL_OFS0 8'h04
`define VCRA_TBL_OFS1 8'h08
`define VCRA_TC0_RST 8'hFF
`define VCRA_TC1_RST 8'h00
`define VCRA_ID1_SET 3'h1
`define VCRA_ID_ZERO 3'h0
`define VCRA_SEL_RR 3'h0
`define VCRA_SEL_WRR 3'h3
`define VCRA_SEL_TWRR 3'h4
`define VCRA_REF_CLK 2'h0
`define VCRA_ENTRY_SIZE 2'h2
`define VCRA_ENTRY_MASK 32'h77777777
`define VCRA_TC1_MASK 8'hFE
`define VCRA_REF_CLK_NS 100

`endif

//--- include/vcra_pkg.sv
package vcra_pkg;
   typedef logic [2:0] vcra_sel_type;
   typedef logic [7:0] vcra_tc_type;
   typedef logic [6:0] vcra_slots_type;
endpackage

//--- src/vcra_regs.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`include "vcra_map.svh"

module vcra_regs
   import vcra_pkg::*;
#(
   parameter int LOAD_CYCLES = 4
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic second_channel_strap,
   input wire logic cfg_load,
   input wire logic [7:0] cfg_tc_map,
   input wire logic [6:0] cfg_time_slots,
   input wire logic [1:0] port_table_written,
   input wire logic [1:0] negotiation_pending,
   output logic [1:0] port_table_load,
   output logic [1:0] channel_enable,
   output logic [15:0] traffic_class_channel_map,
   output logic [5:0] arbitration_select,
   output logic [2:0] channel1_identifier,
   output logic [127:0] channel_arbitration_table,
   output logic ext_count_bit0
);

   localparam int CW = $clog2(LOAD_CYCLES + 1);

   initial begin
      if (LOAD_CYCLES < 1) begin
         $error("LOAD_CYCLES must be at least 1");
      end
   end

   // ***************************************************
   // functions
   // ***************************************************
   function automatic logic [31:0] merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] strb
   );
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic vcra_sel_type legal_sel(
      input logic ch,
      input vcra_sel_type v
   );
      vcra_sel_type res;
      res = `VCRA_SEL_RR;
      if (v == `VCRA_SEL_WRR) begin
         res = v;
      end
      if (ch && v == `VCRA_SEL_TWRR) begin
         res = v;
      end
      return res;
   endfunction

   // ***************************************************
   // bus decode
   // ***************************************************
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic acc;
   logic wr;
   logic mapped;
   logic [31:0] rd_d;
   logic ext0_q;

   assign acc = psel & penable & ~pready_q;
   assign wr = acc & pwrite;
   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign ext_count_bit0 = ext0_q;

   always_ff @(posedge clock) begin
      if (reset) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc & ~mapped;
         if (acc && !pwrite) begin
            prdata_q <= rd_d;
         end
      end
   end

   // strap captured while reset is held
   always_ff @(posedge clock) begin
      if (reset) begin
         ext0_q <= second_channel_strap;
      end
   end

   // ***************************************************
   // channel resources
   // ***************************************************
   vcra_tc_type tc_q [2];
   vcra_sel_type sel_q [2];
   vcra_slots_type slots_q [2];
   logic [1:0] en_q;
   logic [2:0] id1_q;
   logic [1:0] tstat_q;
   logic [1:0] neg_q;
   logic [1:0] load_q;
   logic [CW-1:0] cnt_q [2];
   logic [31:0] cap_v [2];
   logic [31:0] ctrl_v [2];
   logic [31:0] stat_v [2];

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         localparam logic [11:0] CAP_A =
            (ch == 0) ? `VCRA_CH0_CAP : `VCRA_CH1_CAP;
         localparam logic [11:0] CTRL_A =
            (ch == 0) ? `VCRA_CH0_CTRL : `VCRA_CH1_CTRL;
         localparam logic [11:0] STAT_A =
            (ch == 0) ? `VCRA_CH0_STAT : `VCRA_CH1_STAT;
         localparam logic IS1 = (ch == 1);
         logic present;
         logic ctrl_wr;
         logic [31:0] wv;
         logic done;

         assign present = IS1 ? ext0_q : 1'b1;
         assign ctrl_wr = wr && paddr == CTRL_A;
         assign wv = merge(ctrl_v[ch], pwdata, pstrb);
         assign done = cnt_q[ch] == CW'(1);

         // bits 14, 15 and reserved fields stay zero
         assign cap_v[ch] = {
            present ? (IS1 ? `VCRA_TBL_OFS1 : `VCRA_TBL_OFS0)
                    : 8'h00,
            1'b0,
            slots_q[ch],
            2'b00,
            6'h00,
            present ? `VCRA_ARB_CAP : 8'h00
         };
         assign ctrl_v[ch] = {
            en_q[ch], 4'h0,
            IS1 ? id1_q : `VCRA_ID_ZERO,
            4'h0, sel_q[ch],
            1'b0,
            8'h00, tc_q[ch]
         };
         assign stat_v[ch] = {14'h0000, neg_q[ch], tstat_q[ch], 16'h0000};

         always_ff @(posedge clock) begin
            if (reset) begin
               tc_q[ch] <= IS1 ? `VCRA_TC1_RST : `VCRA_TC0_RST;
            end else if (ctrl_wr) begin
               tc_q[ch] <= IS1 ? (wv[7:0] & `VCRA_TC1_MASK)
                                : wv[7:0];
            end else if (cfg_load && !IS1) begin
               tc_q[ch] <= cfg_tc_map;
            end
         end

         always_ff @(posedge clock) begin
            if (reset) begin
               sel_q[ch] <= `VCRA_SEL_RR;
               en_q[ch] <= ~IS1;
            end else if (ctrl_wr) begin
               sel_q[ch] <= legal_sel(IS1,
                  wv[`VCRA_SEL_LSB +: 3]);
               en_q[ch] <= wv[`VCRA_EN_BIT];
            end
         end

         always_ff @(posedge clock) begin
            if (reset) begin
               slots_q[ch] <= (IS1 && !second_channel_strap)
                  ? 7'h00 : `VCRA_SLOTS_RST;
            end else if (cfg_load && present) begin
               slots_q[ch] <= cfg_time_slots;
            end
         end

         // load strobe starts a timed table load
         always_ff @(posedge clock) begin
            if (reset) begin
               load_q[ch] <= 1'b0;
               cnt_q[ch] <= '0;
            end else begin
               load_q[ch] <= ctrl_wr && pstrb[2] &&
                  pwdata[`VCRA_LOAD_BIT];
               if (ctrl_wr && pstrb[2] && pwdata[`VCRA_LOAD_BIT]) begin
                  cnt_q[ch] <= CW'(LOAD_CYCLES);
               end else if (cnt_q[ch] != '0) begin
                  cnt_q[ch] <= cnt_q[ch] - CW'(1);
               end
            end
         end

         // a table write in the finishing cycle wins
         always_ff @(posedge clock) begin
            if (reset) begin
               tstat_q[ch] <= 1'b0;
               neg_q[ch] <= 1'b0;
            end else begin
               neg_q[ch] <= negotiation_pending[ch];
               if (port_table_written[ch]) begin
                  tstat_q[ch] <= 1'b1;
               end else if (done) begin
                  tstat_q[ch] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (reset) begin
         id1_q <= second_channel_strap
            ? `VCRA_ID1_SET : `VCRA_ID_ZERO;
      end else if (wr && paddr == `VCRA_CH1_CTRL) begin
         id1_q <= merge(ctrl_v[1], pwdata, pstrb)
            [`VCRA_ID_LSB +: 3];
      end
   end

   assign port_table_load = load_q;
   assign channel_enable = en_q;
   assign traffic_class_channel_map = {tc_q[1], tc_q[0]};
   assign arbitration_select = {sel_q[1], sel_q[0]};
   assign channel1_identifier = id1_q;

   // ***************************************************
   // arbitration table
   // ***************************************************
   logic [31:0] tbl_q [4];

   genvar w;
   generate
      for (w = 0; w < 4; w++) begin : g_tbl
         localparam logic [11:0] TA = `VCRA_TABLE_BASE + 12'(4 * w);
         always_ff @(posedge clock) begin
            if (reset) begin
               tbl_q[w] <= 32'h0000_0000;
            end else if (wr && paddr == TA) begin
               tbl_q[w] <= merge(tbl_q[w], pwdata, pstrb)
                  & `VCRA_ENTRY_MASK;
            end
         end
         assign channel_arbitration_table[32*w +: 32] = tbl_q[w];
      end
   endgenerate

   // ***************************************************
   // read mux
   // ***************************************************
   always_comb begin
      rd_d = 32'h0000_0000;
      mapped = 1'b1;
      unique case (paddr)
         `VCRA_PORT_CAP1: rd_d = {20'h00000, `VCRA_ENTRY_SIZE,
            `VCRA_REF_CLK, 7'h00, ext0_q};
         `VCRA_CH0_CAP: rd_d = cap_v[0];
         `VCRA_CH0_CTRL: rd_d = ctrl_v[0];
         `VCRA_CH0_STAT: rd_d = stat_v[0];
         `VCRA_CH1_CAP: rd_d = cap_v[1];
         `VCRA_CH1_CTRL: rd_d = ctrl_v[1];
         `VCRA_CH1_STAT: rd_d = stat_v[1];
         default: begin
            if (paddr >= `VCRA_TABLE_BASE && paddr <= `VCRA_TABLE_LAST
                && paddr[1:0] == 2'b00) begin
               rd_d = tbl_q[paddr[3:2]];
            end else begin
               mapped = 1'b0;
            end
         end
      endcase
   end

endmodule

//--- verification/vcra_regs_sva.sv
`timescale 1ns/1ns
module vcra_regs_sva
   import vcra_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic second_channel_strap,
   input wire logic [1:0] port_table_load,
   input wire logic [1:0] channel_enable,
   input wire logic [15:0] traffic_class_channel_map,
   input wire logic [5:0] arbitration_select,
   input wire logic [2:0] channel1_identifier,
   input wire logic [127:0] channel_arbitration_table,
   input wire logic ext_count_bit0
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_ready_next: assert property (s_access |=> s_answer)
      else $error("pready missing after access");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("pready without access");
   a_err_answer: assert property (pslverr |-> pready)
      else $error("pslverr outside answer");
   a_map_bit0: assert property (!traffic_class_channel_map[8])
      else $error("channel 1 map bit 0 set");
   a_sel0_legal: assert property (
      arbitration_select[2:0] inside {3'h0, 3'h3})
      else $error("channel 0 select illegal");
   a_sel1_legal: assert property (
      arbitration_select[5:3] inside {3'h0, 3'h3, 3'h4})
      else $error("channel 1 select illegal");
   a_strap_capture: assert property (
      $fell(reset) |-> ext_count_bit0 == $past(second_channel_strap))
      else $error("strap level not captured");
   a_reset_state: assert property (
      $fell(reset) |-> channel_enable == 2'h1
      && traffic_class_channel_map == 16'h00FF)
      else $error("enable or map reset value wrong");
   a_id1_reset: assert property (
      $fell(reset) |-> channel1_identifier == {2'h0, ext_count_bit0})
      else $error("channel 1 identifier reset wrong");
   a_load_pulse: assert property (
      port_table_load[0] |=> !port_table_load[0])
      else $error("load pulse too long");
   a_table_rsvd: assert property (
      (channel_arbitration_table & ~{4{32'h77777777}}) == 128'h0)
      else $error("table reserved bit set");
endmodule
bind vcra_regs vcra_regs_sva u_sva (.clock, .reset, .psel, .penable, .pready,
   .pslverr, .second_channel_strap, .port_table_load, .channel_enable,
   .traffic_class_channel_map, .arbitration_select, .channel1_identifier,
   .channel_arbitration_table, .ext_count_bit0);

//--- verification/tb_vcra_regs.sv
`timescale 1ns/1ns
module tb_vcra_regs
   import vcra_pkg::*;
;
   localparam int LC = 4;
   logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, strap = 1, cfg_load = 0, ext_bit;
   logic [7:0] cfg_tc = 8'h0;
   logic [6:0] cfg_slots = 7'h0;
   logic [1:0] written = 2'h0, neg = 2'h0, load, en;
   logic [15:0] map;
   logic [5:0] sel;
   logic [2:0] id1;
   logic [127:0] tbl;
   int mismatches = 0, checked = 0, loads = 0;
   vcra_regs #(.LOAD_CYCLES(LC)) u_dut (.clock(clock), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .second_channel_strap(strap), .cfg_load(cfg_load),
      .cfg_tc_map(cfg_tc), .cfg_time_slots(cfg_slots),
      .port_table_written(written), .negotiation_pending(neg),
      .port_table_load(load), .channel_enable(en),
      .traffic_class_channel_map(map), .arbitration_select(sel),
      .channel1_identifier(id1), .channel_arbitration_table(tbl),
      .ext_count_bit0(ext_bit));
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (load[0] === 1'b1) loads++;
   end
   // ***************************************************
   // bus and compare tasks
   // ***************************************************
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] r, output logic er);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 40);
      r = prdata;
      er = pslverr;
      if (pready !== 1'b1) begin
         mismatches++;
         $display("mismatch pready expected 1 seen %b", pready);
      end
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic er;
      apb(1, a, d, 4'hF, r, er);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      logic er;
      apb(0, a, 32'h0, 4'h0, r, er);
      chk("read data", e, r);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_reset();
      rd(12'h150, 32'h047F0019);
      rd(12'h154, 32'h800000FF);
      rd(12'h15C, 32'h087F0019);
      rd(12'h160, 32'h01000000);
      rd(12'h144, 32'h00000801);
      chk("strap port", 32'h1, ext_bit);
      chk("map port", 32'h00FF, map);
      chk("id1 port", 32'h1, id1);
      chk("load port", 32'h0, load);
      $display("test reset done");
   endtask
   task automatic t_cfg();
      @(posedge clock);
      cfg_load <= 1; cfg_tc <= 8'h3C; cfg_slots <= 7'h15;
      @(posedge clock);
      cfg_load <= 0;
      rd(12'h150, 32'h04150019);
      rd(12'h15C, 32'h08150019);
      rd(12'h154, 32'h8000003C);
      $display("test cfg done");
   endtask
   task automatic t_select();
      logic [2:0] e0, e1;
      for (int v = 0; v < 8; v++) begin
         e0 = (v == 3) ? 3'h3 : 3'h0;
         e1 = (v == 3 || v == 4) ? 3'(v) : 3'h0;
         wr(12'h154, 32'h0700005B | (v << 17));
         wr(12'h160, 32'h8700005B | (v << 17));
         rd(12'h154, 32'h0000005B | (e0 << 17));
         rd(12'h160, 32'h8700005A | (e1 << 17));
         chk("select port", {e1, e0}, sel);
      end
      chk("enable port", 32'h2, en);
      chk("map port", 32'h5A5B, map);
      chk("id1 port", 32'h7, id1);
      $display("test select done");
   endtask
   task automatic t_load();
      @(posedge clock);
      written <= 2'h1; neg <= 2'h2;
      @(posedge clock);
      written <= 2'h0;
      rd(12'h158, 32'h00010000);
      rd(12'h164, 32'h00020000);
      loads = 0;
      wr(12'h154, 32'h80010000);
      rd(12'h154, 32'h80000000);
      chk("load pulses", 32'h1, loads);
      neg <= 2'h0;
      cyc(LC + 4);
      rd(12'h158, 32'h0);
      rd(12'h164, 32'h0);
      $display("test load done");
   endtask
   task automatic t_table();
      logic [31:0] r;
      logic er;
      for (int i = 0; i < 4; i++) wr(12'h170 + 4 * i, 32'hFEDCBA98 - i);
      apb(1, 12'h170, 32'h00000011, 4'h1, r, er);
      for (int i = 1; i < 4; i++)
         rd(12'h170 + 4 * i,
            (32'hFEDCBA98 - i) & 32'h77777777);
      rd(12'h170, 32'h76543211);
      chk("table port", 32'h76543211, tbl[31:0]);
      chk("table top", 32'h76543215, tbl[127:96]);
      apb(0, 12'h168, 32'h0, 4'h0, r, er);
      chk("unmapped data", 32'h0, r);
      chk("unmapped error", 32'h1, {31'h0, er});
      $display("test table done");
   endtask
   task automatic t_strap_low();
      @(posedge clock);
      strap <= 0; reset <= 1;
      cyc(2);
      reset <= 0;
      rd(12'h15C, 32'h0);
      rd(12'h160, 32'h0);
      rd(12'h144, 32'h00000800);
      chk("strap port", 32'h0, ext_bit);
      chk("id1 port", 32'h0, id1);
      $display("test strap low done");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      cyc(16);
      reset <= 0;
      t_reset();
      t_cfg();
      t_select();
      t_load();
      t_table();
      t_strap_low();
      finish_test();
   end
   initial begin
      #100000;
      mismatches++;
      finish_test();
   end
endmodule
